// [design/rcu_reset_controller.sv]
// Reset controller sequencing hardware, system and core-only resets
// Overview of operation
// - Hardware reset clears everything, controller included
// - System reset clears all but controller
// - Core-only reset touches only the core
// - Core leaves reset ready to boot
// - Resets hold units idle at defaults
// - Low external pin means hardware reset
// - Software or unit requests start system reset
module rcu_reset_controller (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request sources
    input wire logic hw_reset_n_pin,
    input wire rcu_pkg::rcu_sys_req_s sys_req,
    input wire logic core_req,
    // Reset outputs
    output rcu_pkg::rcu_rst_out_s rst_out,
    // Controller status
    output logic hw_seen,
    output logic sys_seen
);
    import rcu_pkg::*;

    // ****************************************
    // Timing summary
    // ****************************************
    // A system request reloads the hold counter on every edge it is seen.
    // Once it drops, peripherals stay in reset for HOLD_CYC more edges,
    // then the core follows one edge later together with its boot pulse.
    // A pin request costs two extra edges in the synchroniser first.
    // Core-only holds load the counter once, not on every edge, and never touch peripherals.
    // Limitation: requests are levels; a pulse that falls between two
    // edges is missed, so sources must hold until the next edge.

    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic pin_meta_ff;  // First stage, read only by second
    logic pin_sync_ff;  // Second stage, safe to use
    logic hw_req;       // Synchronised hardware request

    // Two flops before any logic looks at the pin
    // Reset to the pin's idle high level: a zero here would read as a
    // fresh pin request for two edges after rst lets go
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= hw_reset_n_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Pin is active low: a low level asks for a hardware reset
    assign hw_req = ~pin_sync_ff;

    // ****************************************
    // Request merge
    // ****************************************
    // Sources are not told apart; any one starts the same hold
    logic sys_any;  // Any system reset source
    assign sys_any = |sys_req;

    // ****************************************
    // Sequencer
    // ****************************************
    rcu_state_s cur_ff;   // Registered state
    rcu_state_s nxt_cur;  // Next state

    // Next state computation
    // Defaults keep everything, so quiet edges change nothing
    always_comb begin
        nxt_cur = cur_ff;
        // Boot pulse lasts one cycle unless raised again below
        nxt_cur.out.core_boot = 1'b0;
        // Pin request outranks every other source
        if (hw_req) begin
            // Widest request first; hardware wipes controller history too
            nxt_cur.state = RCU_ST_SYS;
            nxt_cur.cnt = HOLD_CNT;
            nxt_cur.hw_seen = 1'b1;
            nxt_cur.sys_seen = 1'b0;
            nxt_cur.out = OUT_RESET;
        end else if (sys_any) begin
            // Controller bits kept, all units reset
            nxt_cur.state = RCU_ST_SYS;
            nxt_cur.cnt = HOLD_CNT;
            nxt_cur.sys_seen = 1'b1;
            nxt_cur.out = OUT_RESET;
        end else begin
            unique case (cur_ff.state)
                // Running: only a core request starts anything here
                RCU_ST_RUN: begin
                    if (core_req) begin
                        // Only the core is touched, peripherals run on
                        nxt_cur.state = RCU_ST_CORE;
                        nxt_cur.cnt = HOLD_CNT;
                        nxt_cur.out.core_rst = 1'b1;
                        nxt_cur.out.core_busy = 1'b1;
                    end
                end
                // System hold, counting down after the last request
                RCU_ST_SYS: begin
                    if (cur_ff.cnt != CNT_ZERO) begin
                        nxt_cur.cnt = cur_ff.cnt - 4'h1;
                    end else begin
                        // Release peripherals, core goes through boot step
                        nxt_cur.out.periph_rst = 1'b0;
                        nxt_cur.state = RCU_ST_CORE;
                        nxt_cur.cnt = CNT_ZERO;
                    end
                end
                // Core-only hold, stretched while the request stays high
                RCU_ST_CORE: begin
                    if (cur_ff.cnt != CNT_ZERO || core_req) begin
                        // Held while requested, keeps core idle
                        nxt_cur.cnt = (cur_ff.cnt != CNT_ZERO) ? cur_ff.cnt - 4'h1 : CNT_ZERO;
                    end else begin
                        nxt_cur.state = RCU_ST_BOOT;
                        nxt_cur.out.core_rst = 1'b0;
                        nxt_cur.out.core_boot = 1'b1;
                    end
                end
                RCU_ST_BOOT: begin
                    // Access allowed one cycle after boot pulse
                    nxt_cur.state = RCU_ST_RUN;
                    nxt_cur.out.core_busy = 1'b0;
                end
                // Corrupt state code: recover through a full system hold
                default: begin
                    nxt_cur.state = RCU_ST_SYS;
                    nxt_cur.cnt = HOLD_CNT;
                    nxt_cur.out = OUT_RESET;
                end
            endcase
        end
    end

    // State register; async reset acts as hardware reset
    // Only constants in the reset branch, so it stays a plain preset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_ff.state <= RCU_ST_SYS;
            cur_ff.cnt <= HOLD_CNT;
            cur_ff.hw_seen <= 1'b1;
            cur_ff.sys_seen <= 1'b0;
            cur_ff.out <= OUT_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Straight from the state register, no logic after the flops
    assign rst_out = cur_ff.out; // Reset lines to the units
    assign hw_seen = cur_ff.hw_seen; // Hardware reset history
    assign sys_seen = cur_ff.sys_seen; // System reset history

    // ****************************************
    // Assertions
    // ****************************************
    // All checks sample on the system clock and sleep during rst
    // Core request from idle resets the core alone
    a_core_only_scope: assert property (@(posedge clk_sys) disable iff (rst)
        (cur_ff.state == RCU_ST_RUN && !hw_req && !sys_any && core_req)
        |=> (rst_out.core_rst && !rst_out.periph_rst))
        else $error("core-only reset disturbed peripherals");
    // System request resets every unit and records itself
    a_sys_resets_all: assert property (@(posedge clk_sys) disable iff (rst)
        sys_any && !hw_req |=> rst_out.periph_rst && rst_out.core_rst && sys_seen)
        else $error("system reset did not reset all units");
    // Hardware request wipes the system history
    a_hw_clears_hist: assert property (@(posedge clk_sys) disable iff (rst)
        hw_req |=> hw_seen && !sys_seen && rst_out.periph_rst)
        else $error("hardware reset kept history");
    // A synchronised low pin resets core and peripherals
    a_pin_to_reset: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(pin_sync_ff) |=> rst_out.periph_rst && rst_out.core_rst)
        else $error("pin low did not reset");
    // Every core release carries exactly one boot pulse
    a_boot_after_core: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst_out.core_rst) |-> rst_out.core_boot ##1 !rst_out.core_boot)
        else $error("core release without boot pulse");
    // Core in reset is never offered to bus masters
    a_idle_in_reset: assert property (@(posedge clk_sys) disable iff (rst)
        rst_out.core_rst |-> rst_out.core_busy)
        else $error("core reachable while in reset");
    // Core request loses to a wider pending request
    a_widest_wins: assert property (@(posedge clk_sys) disable iff (rst)
        (sys_any || hw_req) && core_req |=> rst_out.periph_rst)
        else $error("narrower reset chosen over wider");
    // System reset lasts at least the hold time
    a_sys_hold_time: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rst_out.periph_rst) |-> rst_out.periph_rst [*8])
        else $error("system reset held too briefly");

    // Peripherals only enter reset through a hardware or system request
    a_periph_untouched: assert property (@(posedge clk_sys) disable iff (rst)
        !rst_out.periph_rst && !hw_req && !sys_any |=> !rst_out.periph_rst)
        else $error("peripherals reset without a system request");
    // Core is never released while peripherals are still held
    a_sys_covers_core: assert property (@(posedge clk_sys) disable iff (rst)
        rst_out.periph_rst |-> rst_out.core_rst)
        else $error("core released before peripherals");
    // Boot pulse comes with the core out of reset and still fenced off
    a_boot_ready_state: assert property (@(posedge clk_sys) disable iff (rst)
        rst_out.core_boot |-> !rst_out.core_rst && !rst_out.periph_rst && rst_out.core_busy)
        else $error("boot pulse in wrong reset state");
    // Core answers again one cycle after its boot pulse
    a_busy_after_boot: assert property (@(posedge clk_sys) disable iff (rst)
        rst_out.core_boot && !hw_req && !sys_any |=> !rst_out.core_busy)
        else $error("core still fenced after boot");
    // Core-only reset lasts at least the hold time
    a_core_hold_time: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(rst_out.core_rst) && !rst_out.periph_rst |-> rst_out.core_rst [*8])
        else $error("core-only reset held too briefly");
endmodule

// [design/rcu_pkg.sv]
// Package of constants and types for the reset controller
package rcu_pkg;

    // ****************************************
    // Timing constants
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 8;        // System clock period
    localparam int unsigned HOLD_TIME_NS = 64;        // Least time a reset output is held
    // Hold cycles, rounded up to whole cycles
    localparam int unsigned HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);  // Counter load value
    localparam logic [3:0] CNT_ZERO = 4'h0;          // Counter idle value

    // ****************************************
    // Reset target encoding (one-hot states)
    // ****************************************
    typedef enum logic [3:0] {
        RCU_ST_RUN  = 4'h1,  // No reset applied
        RCU_ST_SYS  = 4'h2,  // System reset held
        RCU_ST_CORE = 4'h4,  // Core-only reset held
        RCU_ST_BOOT = 4'h8   // Core released, boot request pulse
    } rcu_state_e;

    // ****************************************
    // Carriers
    // ****************************************
    // System reset request sources
    typedef struct packed {
        logic sw_ctrl;        // Software write of reset_ctrl_reg
        logic power_mode;     // power_mode_unit request
        logic event_ctrl;     // event_controller request
        logic trig_router;    // trigger_router request
        logic emulator;       // Emulator input request
    } rcu_sys_req_s;

    // Reset outputs to functional units
    typedef struct packed {
        logic core_rst;       // Processor core reset
        logic periph_rst;     // Peripheral units reset
        logic core_boot;      // Core ready-to-boot pulse
        logic core_busy;      // Core unreachable, bus masters must wait
    } rcu_rst_out_s;

    // Whole module state
    typedef struct packed {
        rcu_state_e state;    // Sequencer state
        logic [3:0] cnt;      // Hold counter
        logic hw_seen;        // Set by hardware reset, survives system reset
        logic sys_seen;       // Set by system reset, cleared by hardware reset
        rcu_rst_out_s out;    // Registered outputs
    } rcu_state_s;

    localparam rcu_rst_out_s OUT_RESET = '{core_rst: 1'b1, periph_rst: 1'b1,
                                           core_boot: 1'b0, core_busy: 1'b1};

endpackage

// [dv/rcu_core_model.sv]
// Stand-in for the core behind the reset outputs
module rcu_core_model (
    // Clock
    input wire logic clk_sys,
    // Reset outputs from the controller
    input wire rcu_pkg::rcu_rst_out_s rst_out,
    // Boots seen so far
    output int boots
);
    timeunit 1ns;
    timeprecision 1ps;
    import rcu_pkg::*;
    logic probe; // Bus master poking the core
    initial boots = 0;
    initial probe = 1'b0;
    // Probe only while the core answers; a probe into reset would hang a real bus
    always @(posedge clk_sys) begin
        probe <= !rst_out.core_busy && !probe;
        if (rst_out.core_boot === 1'b1) begin
            boots <= boots + 1;
        end
    end
endmodule

// [dv/tb_rcu_reset_controller.sv]
// Self-checking bench for the reset controller
module tb_rcu_reset_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import rcu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n_pin = 1'b1;
    rcu_sys_req_s sys_req = '0;
    logic core_req = 1'b0;
    rcu_rst_out_s rst_out;
    logic hw_seen;
    logic sys_seen;
    int boots;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] lfsr = 32'hc75e; // Random source
    logic [3:0] expq[$]; // Expected cause view at each boot pulse
    rcu_reset_controller dut (.clk_sys(clk_sys), .rst(rst), .hw_reset_n_pin(hw_reset_n_pin),
        .sys_req(sys_req), .core_req(core_req), .rst_out(rst_out), .hw_seen(hw_seen),
        .sys_seen(sys_seen));
    rcu_core_model core (.clk_sys(clk_sys), .rst_out(rst_out), .boots(boots));
    initial forever #4 clk_sys = ~clk_sys;
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Status view: periph reset, core reset, busy, sticky system flag
    function automatic logic [3:0] view();
        return {rst_out.periph_rst, rst_out.core_rst, rst_out.core_busy, sys_seen};
    endfunction
    // Cause view: periph reset, core reset, both history flags
    function automatic logic [3:0] cause();
        return {rst_out.periph_rst, rst_out.core_rst, hw_seen, sys_seen};
    endfunction
    task automatic edge_look();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Bounded wait for the core to answer again
    task automatic wait_idle();
        for (int i = 0; i < 60 && rst_out.core_busy !== 1'b0; i++) @(negedge clk_sys);
        @(posedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Boot watcher: each boot pulse must match the oldest note
    always @(negedge clk_sys) begin
        cycles++;
        // Ceiling well above the fewer than two hundred cycles the tests need
        if (cycles > 2000) begin
            fails++;
            report_and_stop();
        end else if (rst_out.core_boot === 1'b1) begin
            chk(cause(), expq.size() > 0 ? expq.pop_front() : 4'hf);
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (6) @(negedge clk_sys);
        chk(cause(), 4'he);
        expq.push_back(4'h2);
        @(posedge clk_sys);
        rst <= 1'b0;
        wait_idle();
        // Every system source, random hold, exact release count
        for (int k = 0; k < 5; k++) begin
            sys_req <= rcu_sys_req_s'(5'h1 << k);
            edge_look();
            chk(view(), 4'hf);
            lfsr = lfsr_next(lfsr);
            repeat (lfsr[1:0] + 1) @(posedge clk_sys);
            sys_req <= '0;
            expq.push_back(4'h3);
            // Last edge of the hold; peripherals go on the next one
            repeat (8) @(posedge clk_sys);
            @(negedge clk_sys);
            chk(view(), 4'hf);
            edge_look();
            chk(view(), 4'h7);
            wait_idle();
            $display("test system source %0d done", k);
        end
        // Core-only reset leaves peripherals alone
        core_req <= 1'b1;
        edge_look();
        chk(view(), 4'h7);
        repeat (10) @(posedge clk_sys);
        core_req <= 1'b0;
        expq.push_back(4'h3);
        wait_idle();
        $display("test core reset done");
        // Both pending: the wider one wins
        core_req <= 1'b1;
        sys_req <= rcu_sys_req_s'(lfsr[4:0] | 5'h1);
        edge_look();
        chk(view(), 4'hf);
        @(posedge clk_sys);
        core_req <= 1'b0;
        sys_req <= '0;
        expq.push_back(4'h3);
        wait_idle();
        $display("test priority done");
        // Pin low is a hardware reset and wipes history
        hw_reset_n_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(cause(), 4'he);
        @(posedge clk_sys);
        hw_reset_n_pin <= 1'b1;
        expq.push_back(4'h2);
        wait_idle();
        $display("test pin reset done");
        // Mid-run rst after a system reset must wipe that history too
        sys_req <= rcu_sys_req_s'(5'h2);
        edge_look();
        chk(view(), 4'hf);
        @(posedge clk_sys);
        sys_req <= '0;
        rst <= 1'b1;
        @(negedge clk_sys);
        chk(cause(), 4'he);
        @(posedge clk_sys);
        rst <= 1'b0;
        expq.push_back(4'h2);
        wait_idle();
        chk(4'(boots), 4'ha);
        chk(4'(expq.size()), 4'h0);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
